// ### ccu_pkg.sv
// ccu_pkg: constants and types of the checksum computing unit
// assumes: included before ccu_top; a 125 MHz system clock
`default_nettype none
package ccu_pkg;
	localparam int          CCU_CLK_MHZ      = 125;
	localparam int          CCU_ADDR_W       = 8;
	localparam logic [31:0] CCU_POLY         = 32'h04C11DB7;
	localparam int          CCU_UPDATE_CYC   = 4;
	// register byte offsets
	localparam logic [7:0]  CCU_OFS_DATA     = 8'h00;
	localparam logic [7:0]  CCU_OFS_SCRATCH  = 8'h04;
	localparam logic [7:0]  CCU_OFS_CTRL     = 8'h08;
	localparam logic [7:0]  CCU_OFS_SEED     = 8'h10;
	// reset values
	localparam logic [31:0] CCU_DATA_RST     = 32'hFFFFFFFF;
	localparam logic [31:0] CCU_SEED_RST     = 32'hFFFFFFFF;
	localparam logic [7:0]  CCU_SCRATCH_RST  = 8'h00;
	// control field positions
	localparam int          CCU_CTRL_RELOAD  = 0;
	localparam int          CCU_CTRL_INPUT_BIT_ORDER_SELECT_LO = 5;
	localparam int          CCU_CTRL_OUTPUT_BIT_ORDER_FLIP    = 7;
	// byte counts of one update
	localparam logic [2:0]  CCU_N_BYTE       = 3'h1;
	localparam logic [2:0]  CCU_N_HALF       = 3'h2;
	localparam logic [2:0]  CCU_N_WORD       = 3'h4;

	typedef enum logic [1:0] {
		CCU_REV_NONE,
		CCU_REV_BYTE,
		CCU_REV_HALF,
		CCU_REV_WORD
	} ccu_rev_e;

	// one pending update: left-aligned data and its byte count
	typedef struct packed {
		logic [2:0]  nbytes;
		logic [31:0] data;
	} ccu_job_s;

	// control register state
	typedef struct packed {
		logic        output_bit_order_flip;
		ccu_rev_e    input_bit_order_select;
	} ccu_ctrl_s;
endpackage
`default_nettype wire

// ### ccu_top.sv
// ccu_top: memory-mapped 32-bit checksum unit, APB slave
// assumes: APB master on sys_clk, pstrb gives the write width, all inputs synchronous
// Overview of operation
// - The remainder is updated with the fixed generator 0x04C11DB7 and kept between writes.
// - An update on an idle engine finishes within four clock cycles of the data write; a buffered one first waits for the running one.
// - Writes of 8, 16 or 32 bits are processed as a byte, half-word or word.
// - Each write's own width decides how many bytes that update processes.
// - Each new write folds into the previous result, giving one running checksum.
// - Accesses that would race an update are held off by keeping pready low.
// - A one-entry input buffer lets a second write land while an update runs.
// - Writing the data register feeds the engine, reading it returns the checksum, reset all ones.
// - Input buffer and result register are separate, so input never overwrites the result.
// - The scratch byte stores any byte and is untouched by the calculation and reload.
// - Writing one to control bit 0 reloads the result, and hardware clears the bit.
// - Control bits 6:5 choose input bit reversal: none, per byte, per half-word, per word, each capped at the write width.
// - Control bit 7 returns the checksum bit-reversed on data reads.
// - Registers decode at data 0x00, scratch 0x04, control 0x08, seed 0x10.
// - The seed register is software writable and resets to all ones.
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module ccu_top (
	input  wire logic                           sys_clk,
	input  wire logic                           rst,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [ccu_pkg::CCU_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                    pwdata,
	input  wire logic [3:0]                     pstrb,
	output logic                                pready,
	output logic      [31:0]                    prdata,
	output logic                                pslverr
);
	import ccu_pkg::*;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[31] ^ b[i]) begin
				r = {r[30:0], 1'b0} ^ CCU_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction

	// reverse bits inside each group of w bits
	function automatic logic [31:0] rev_in(input logic [31:0] d, input int w);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 32; i++) begin
			r[i] = d[(i / w) * w + (w - 1 - (i % w))];
		end
		return r;
	endfunction

	logic [31:0] crc;
	logic [31:0] seed;
	logic [7:0]  scratch;
	ccu_ctrl_s   ctrl;
	logic        reload_pend;
	ccu_job_s    buf_job;
	logic        buf_valid;
	logic [2:0]  eng_cnt;
	logic [31:0] eng_sh;
	logic        stall_d;

	logic        access;
	logic        hit_data;
	logic        hit_scratch;
	logic        hit_ctrl;
	logic        hit_seed;
	logic        strb_bad;
	logic        stall;
	logic        busy;
	logic        wr_fire;
	logic        data_wr;
	logic        eng_last;
	ccu_job_s    new_job;
	logic [31:0] next_prdata;

	assign access = psel && penable;
	// address decoding
	always_comb begin
		hit_data    = 1'b0;
		hit_scratch = 1'b0;
		hit_ctrl    = 1'b0;
		hit_seed    = 1'b0;
		if (paddr == CCU_OFS_DATA) begin
			hit_data = 1'b1;
		end else if (paddr == CCU_OFS_SCRATCH) begin
			hit_scratch = 1'b1;
		end else if (paddr == CCU_OFS_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (paddr == CCU_OFS_SEED) begin
			hit_seed = 1'b1;
		end
	end

	// write width from the byte strobes, left-aligned for msb-first feeding
	always_comb begin
		logic [31:0] v;
		logic [31:0] r;
		v        = '0;
		r        = '0;
		strb_bad = 1'b0;
		new_job  = '{nbytes: CCU_N_WORD, data: '0};
		case (pstrb)
			4'h1, 4'h2, 4'h4, 4'h8: begin
				new_job.nbytes = CCU_N_BYTE;
				v = pwdata >> (8 * (pstrb == 4'h2 ? 1 : pstrb == 4'h4 ? 2 : pstrb == 4'h8 ? 3 : 0));
			end
			4'h3, 4'hC: begin
				new_job.nbytes = CCU_N_HALF;
				v = pstrb == 4'hC ? {16'h0000, pwdata[31:16]} : {16'h0000, pwdata[15:0]};
			end
			4'hF, 4'h0: begin
				new_job.nbytes = CCU_N_WORD;
				v = pwdata;
			end
			default: begin
				strb_bad = 1'b1;
			end
		endcase
		// reversal unit never exceeds the write width
		r = v;
		case (ctrl.input_bit_order_select)
			CCU_REV_BYTE: r = rev_in(v, 8);
			CCU_REV_HALF: r = new_job.nbytes == CCU_N_BYTE ? rev_in(v, 8) : rev_in(v, 16);
			CCU_REV_WORD: begin
				if (new_job.nbytes == CCU_N_BYTE) begin
					r = rev_in(v, 8);
				end else if (new_job.nbytes == CCU_N_HALF) begin
					r = rev_in(v, 16);
				end else begin
					r = rev_in(v, 32);
				end
			end
			default: r = v;
		endcase
		new_job.data = r << (6'd32 - {new_job.nbytes, 3'b000});
	end

	assign busy     = (eng_cnt != 3'h0) || buf_valid || reload_pend;
	assign eng_last = eng_cnt == 3'h1;
	always_comb begin
		stall = 1'b0;
		if (hit_data && pwrite) begin
			stall = reload_pend || (buf_valid && eng_cnt != 3'h0);
		end else if (hit_data || hit_ctrl) begin
			stall = busy;
		end
	end
	assign pready  = access && !stall && !stall_d;
	assign pslverr = access && pready && (!(hit_data || hit_scratch || hit_ctrl || hit_seed)
		|| (pwrite && hit_data && strb_bad));
	assign wr_fire = access && pready && pwrite && !pslverr;
	assign data_wr = wr_fire && hit_data;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stall_d <= 1'b0;
		end else begin
			stall_d <= psel && stall;
		end
	end

	// read mux, registered; stall_d guarantees the sampled state is settled
	always_comb begin
		next_prdata = '0;
		if (hit_data) begin
			next_prdata = ctrl.output_bit_order_flip ? rev_in(crc, 32) : crc;
		end else if (hit_scratch) begin
			next_prdata = {24'h000000, scratch};
		end else if (hit_ctrl) begin
			next_prdata[CCU_CTRL_RELOAD] = reload_pend;
			next_prdata[CCU_CTRL_INPUT_BIT_ORDER_SELECT_LO +: 2] = ctrl.input_bit_order_select;
			next_prdata[CCU_CTRL_OUTPUT_BIT_ORDER_FLIP] = ctrl.output_bit_order_flip;
		end else if (hit_seed) begin
			next_prdata = seed;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scratch <= CCU_SCRATCH_RST;
		end else if (wr_fire && hit_scratch) begin
			scratch <= pwdata[7:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seed <= CCU_SEED_RST;
		end else if (wr_fire && hit_seed) begin
			seed <= pwdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl        <= '{output_bit_order_flip: 1'b0, input_bit_order_select: CCU_REV_NONE};
			reload_pend <= 1'b0;
		end else begin
			reload_pend <= 1'b0;
			if (wr_fire && hit_ctrl) begin
				ctrl.input_bit_order_select <= ccu_rev_e'(pwdata[CCU_CTRL_INPUT_BIT_ORDER_SELECT_LO +: 2]);
				ctrl.output_bit_order_flip  <= pwdata[CCU_CTRL_OUTPUT_BIT_ORDER_FLIP];
				reload_pend                 <= pwdata[CCU_CTRL_RELOAD];
			end
		end
	end

	// input buffer: takes a write only while the engine is still busy
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buf_valid <= 1'b0;
			buf_job   <= '0;
		end else begin
			if (data_wr && eng_cnt > 3'h1) begin
				buf_valid <= 1'b1;
				buf_job   <= new_job;
			end else if (eng_last) begin
				buf_valid <= 1'b0;
			end
		end
	end

	// engine: one byte per cycle, word in four cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eng_cnt <= 3'h0;
			eng_sh  <= '0;
		end else begin
			if (eng_last && buf_valid) begin
				eng_cnt <= buf_job.nbytes;
				eng_sh  <= buf_job.data;
			end else if (data_wr && eng_cnt <= 3'h1) begin
				eng_cnt <= new_job.nbytes;
				eng_sh  <= new_job.data;
			end else if (eng_cnt != 3'h0) begin
				eng_cnt <= eng_cnt - 3'h1;
				eng_sh  <= {eng_sh[23:0], 8'h00};
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			crc <= CCU_DATA_RST;
		end else if (reload_pend) begin
			crc <= seed;
		end else if (eng_cnt != 3'h0) begin
			crc <= crc_byte(crc, eng_sh[31:24]);
		end
	end

	a_word_update_time: assert property (@(posedge sys_clk) disable iff (rst)
		(data_wr && eng_cnt == 3'h0 && new_job.nbytes == CCU_N_WORD) |-> ##4 eng_cnt == 3'h1)
		else $error("word update exceeded four cycles");
	a_byte_step_count: assert property (@(posedge sys_clk) disable iff (rst)
		(eng_cnt > 3'h1) |=> eng_cnt == $past(eng_cnt) - 3'h1)
		else $error("engine byte count did not step");
	a_crc_fold_step: assert property (@(posedge sys_clk) disable iff (rst)
		(eng_cnt != 3'h0 && !reload_pend) |=> crc == crc_byte($past(crc), $past(eng_sh[31:24])))
		else $error("result not folded with previous value");
	a_write_stall_full: assert property (@(posedge sys_clk) disable iff (rst)
		(access && pwrite && hit_data && buf_valid && eng_cnt != 3'h0) |-> !pready)
		else $error("write accepted with full buffer");
	a_reload_seed_load: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_fire && hit_ctrl && pwdata[0]) |=> reload_pend ##1 (!reload_pend && crc == $past(seed)))
		else $error("reload did not load seed and self clear");
	a_read_out_order: assert property (@(posedge sys_clk) disable iff (rst)
		(pready && !pwrite && hit_data) |->
		prdata == (ctrl.output_bit_order_flip ? rev_in(crc, 32) : crc))
		else $error("data read returns wrong result order");
	a_scratch_kept_reload: assert property (@(posedge sys_clk) disable iff (rst)
		reload_pend |=> $stable(scratch))
		else $error("scratch byte changed on reload");
	a_unmapped_err_resp: assert property (@(posedge sys_clk) disable iff (rst)
		(access && !stall_d && !(hit_data || hit_scratch || hit_ctrl || hit_seed))
		|-> (pready && pslverr))
		else $error("unmapped access not answered with error");
	a_ctrl_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(pready && !pwrite && hit_ctrl) |-> prdata[31:8] == 24'h000000)
		else $error("reserved control bits not zero");

	c_word_write: cover property (@(posedge sys_clk) disable iff (rst)
		data_wr && new_job.nbytes == CCU_N_WORD);
	c_buffered_write: cover property (@(posedge sys_clk) disable iff (rst)
		data_wr && eng_cnt > 3'h1);
	c_stalled_write: cover property (@(posedge sys_clk) disable iff (rst)
		access && pwrite && hit_data && !pready);
	c_reload_seen: cover property (@(posedge sys_clk) disable iff (rst) reload_pend);
endmodule
`default_nettype wire

// ### ccu_host.sv
// ccu_host: processor side of the checksum unit, issues apb transfers
// assumes: its task is called from tb, shares sys_clk with the unit
`default_nettype none
module ccu_host (
	input  wire logic                           sys_clk,
	output var  logic                           psel,
	output var  logic                           penable,
	output var  logic                           pwrite,
	output var  logic [ccu_pkg::CCU_ADDR_W-1:0] paddr,
	output var  logic [31:0]                    pwdata,
	output var  logic [3:0]                     pstrb,
	input  wire logic                           pready,
	input  wire logic [31:0]                    prdata,
	input  wire logic                           pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccu_pkg::*;
	logic err = 1'b0;
	logic held = 1'b0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// setup, access held until pready at an edge, then release;
	// hold keeps psel up so the next setup follows at once
	task automatic xfer(input logic w, input logic [CCU_ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] s, input logic hold,
		output logic [31:0] q);
		logic rdy;
		rdy = 1'b0;
		q = '0;
		if (!held) begin
			@(posedge sys_clk);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		// answer looked at mid-cycle, where it is settled, and taken at the next edge
		while (rdy !== 1'b1) begin
			@(negedge sys_clk);
			rdy = pready;
			q = prdata;
			err = pslverr;
			@(posedge sys_clk);
		end
		penable <= 1'b0;
		held = hold;
		if (!hold) begin
			psel <= 1'b0;
			// released address and data lines do not keep their last value; pwrite and pstrb do
			pwdata <= ~d;
			paddr <= ~a;
		end
	endtask
endmodule
`default_nettype wire

// ### ccu_tb.sv
// ccu_tb: self-checking bench of the checksum unit
// assumes: ccu_pkg, ccu_top and ccu_host are compiled first
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccu_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, exp;
	logic [3:0]  pstrb;
	int          mismatches = 0;
	int          n_checks = 0;
	always #4 sys_clk = ~sys_clk;
	ccu_top u_ccu_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	ccu_host u_ccu_host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	function automatic logic [31:0] brev(input logic [31:0] v, input int w);
		logic [31:0] r;
		for (int i = 0; i < 32; i++)
			r[i] = v[(i / w) * w + w - 1 - i % w];
		return r;
	endfunction
	// msb-first remainder update, data left-aligned
	function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d,
		input int nb);
		for (int i = 0; i < nb * 8; i++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[31 - i]) ? CCU_POLY : 32'h0);
		return c;
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		u_ccu_host.xfer(1'b1, a, d, s, 1'b0, q);
	endtask
	// write whose next setup cycle follows at once
	task automatic wr_next(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		u_ccu_host.xfer(1'b1, a, d, s, 1'b1, q);
	endtask
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		u_ccu_host.xfer(1'b0, a, 32'h0, 4'h0, 1'b0, q);
		chk(nm, e, q);
	endtask
	initial begin
		#20000;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		chk_rd("data rst", CCU_OFS_DATA, CCU_DATA_RST);
		chk_rd("seed rst", CCU_OFS_SEED, CCU_SEED_RST);
		chk_rd("scratch rst", CCU_OFS_SCRATCH, 32'h0);
		chk_rd("ctrl rst", CCU_OFS_CTRL, 32'h0);
		// word, byte and half writes close together: buffered then stalled
		wr_next(CCU_OFS_DATA, 32'h12345678, 4'hF);
		wr_next(CCU_OFS_DATA, 32'h00AB0000, 4'h4);
		wr(CCU_OFS_DATA, 32'hC3D20000, 4'hC);
		exp = fold(fold(fold(CCU_DATA_RST, 32'h12345678, 4), 32'hAB000000, 1), 32'hC3D20000, 2);
		chk_rd("crc mixed", CCU_OFS_DATA, exp);
		for (int m = 0; m < 4; m++) begin
			wr(CCU_OFS_CTRL, 32'(m) << 5, 4'hF);
			wr(CCU_OFS_DATA, 32'h0F1E2D3C, 4'hF);
			exp = fold(exp, (m == 0) ? 32'h0F1E2D3C : brev(32'h0F1E2D3C, 4 << m), 4);
			chk_rd("crc rev in", CCU_OFS_DATA, exp);
		end
		wr(CCU_OFS_CTRL, 32'hFFFFFF80, 4'hF);
		chk_rd("ctrl rsvd", CCU_OFS_CTRL, 32'h00000080);
		chk_rd("crc rev out", CCU_OFS_DATA, brev(exp, 32));
		wr(CCU_OFS_DATA, 32'h000000A5, 4'h1);
		wr(CCU_OFS_DATA, 32'h00001234, 4'h3);
		chk("write err", 32'h0, {31'h0, u_ccu_host.err});
		exp = fold(fold(exp, 32'hA5000000, 1), 32'h12340000, 2);
		chk_rd("crc lanes", CCU_OFS_DATA, brev(exp, 32));
		wr(CCU_OFS_SEED, 32'h5A5AC3C3, 4'hF);
		chk_rd("seed", CCU_OFS_SEED, 32'h5A5AC3C3);
		wr(CCU_OFS_SCRATCH, 32'hFFFFFF3C, 4'hF);
		wr(CCU_OFS_CTRL, 32'h00000001, 4'hF);
		chk_rd("ctrl clr", CCU_OFS_CTRL, 32'h0);
		chk_rd("data reload", CCU_OFS_DATA, 32'h5A5AC3C3);
		chk_rd("scratch", CCU_OFS_SCRATCH, 32'h0000003C);
		chk_rd("unmapped", 8'h0C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, u_ccu_host.err});
		stop_test;
	end
endmodule
`default_nettype wire
